// file: logic/pcbu_core.sv
// Program control branch unit: fetch, decode and execute of branch opcodes
module pcbu_core
  import pcbu_pkg::*;
#(
  parameter int TSTATE_DIV = TSTATE_DIV_DEF
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] MEM_RDATA_I,
  input wire logic [7:0] FLAGS_I,
  input wire logic [15:0] FIRST_INDEX_I,
  input wire logic [15:0] SECOND_INDEX_I,
  input wire logic [7:0] LOOP_COUNT_I,
  input wire logic STACK_LOAD_I,
  input wire logic [15:0] STACK_VALUE_I,
  output logic TSTATE_O,
  output logic [15:0] MEM_ADDR_O,
  output logic [7:0] MEM_WDATA_O,
  output logic MEM_RD_O,
  output logic MEM_WR_O,
  output logic OPFETCH_O,
  output logic [7:0] LOOP_COUNT_O,
  output logic LOOP_COUNT_WE_O,
  output logic [15:0] PROGRAM_COUNTER_O,
  output logic [15:0] STACK_POINTER_O,
  output logic [1:0] INTERRUPT_MODE_O,
  output logic IRQ_EXIT_O,
  output logic UNHANDLED_O,
  output logic INSN_DONE_O
);
  // ==========================================================
  // Helpers
  // ==========================================================
  // Condition test, three-bit field
  function automatic logic cond_met(input logic [2:0] c, input logic [7:0] f);
    logic r;
    r = 1'b0;
    unique case (c)
      3'h0: r = !f[FLAG_Z];
      3'h1: r = f[FLAG_Z];
      3'h2: r = !f[FLAG_C];
      3'h3: r = f[FLAG_C];
      3'h4: r = !f[FLAG_PV];
      3'h5: r = f[FLAG_PV];
      3'h6: r = !f[FLAG_S];
      3'h7: r = f[FLAG_S];
    endcase
    return r;
  endfunction : cond_met

  // ==========================================================
  // State
  // ==========================================================
  logic tick;  // T state enable
  pcbu_state_t state_r, state_nxt;  // Sequencer step
  pcbu_cls_t cls_r, cls_nxt;  // Instruction class
  logic [7:0] pfx_r, pfx_nxt;  // First prefix byte
  logic take_r, take_nxt;  // Branch or push will happen
  logic [4:0] tcnt_r, tcnt_nxt;  // T states used so far
  logic [4:0] ttot_r, ttot_nxt;  // T states of this instruction
  logic [15:0] tgt_r, tgt_nxt;  // Pending branch target
  logic [15:0] pc_r, pc_nxt;  // Program counter
  logic [15:0] sp_r, sp_nxt;  // Stack pointer
  logic [1:0] im_r, im_nxt;  // Interrupt mode
  logic [15:0] addr_r, addr_nxt;  // Bus address
  logic [7:0] wdata_r, wdata_nxt;  // Bus write data
  logic rd_r, rd_nxt;  // Bus read
  logic wr_r, wr_nxt;  // Bus write
  logic m1_r, m1_nxt;  // Opcode fetch marker
  logic [7:0] cnt_r, cnt_nxt;  // Loop count result
  logic cnt_we_r, cnt_we_nxt;  // Loop count strobe
  logic irqx_r, irqx_nxt;  // Interrupt exit seen
  logic unh_r, unh_nxt;  // Opcode not handled here
  logic done_r, done_nxt;  // Instruction end
  logic last;  // Final T state of instruction
  logic [7:0] dec;  // Decremented loop count

  pcbu_tstate_div #(.DIV(TSTATE_DIV)) u_div (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .tick_o(tick)
  );

  assign last = tick && state_r == S_PAD && tcnt_r == ttot_r - 5'h01;
  assign dec = LOOP_COUNT_I - 8'h01;

  // ==========================================================
  // Next state: decode, sequence and bus setup
  // ==========================================================
  always_comb begin
    state_nxt = state_r;
    cls_nxt = cls_r;
    pfx_nxt = pfx_r;
    take_nxt = take_r;
    tcnt_nxt = tcnt_r;
    ttot_nxt = ttot_r;
    tgt_nxt = tgt_r;
    pc_nxt = pc_r;
    sp_nxt = sp_r;
    im_nxt = im_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    m1_nxt = m1_r;
    cnt_nxt = cnt_r;
    cnt_we_nxt = 1'b0;
    irqx_nxt = 1'b0;
    unh_nxt = 1'b0;
    done_nxt = 1'b0;
    if (tick) begin
      tcnt_nxt = tcnt_r + 5'h01;
      unique case (state_r)
        // Opcode byte; flags are only read, never written
        S_FETCH: begin
          pc_nxt = pc_r + 16'h0001;
          tcnt_nxt = 5'h01;
          take_nxt = 1'b1;
          state_nxt = S_PAD;
          if (MEM_RDATA_I == OP_ABS) begin
            cls_nxt = CL_ABS;
            ttot_nxt = T_ABS;
            state_nxt = S_OPLO;
          end else if (MEM_RDATA_I[7:6] == 2'b11 && MEM_RDATA_I[2:0] == 3'h2) begin
            cls_nxt = CL_ABS_C;
            take_nxt = cond_met(MEM_RDATA_I[5:3], FLAGS_I);
            ttot_nxt = T_ABS;
            state_nxt = S_OPLO;
          end else if (MEM_RDATA_I == OP_REL) begin
            cls_nxt = CL_REL;
            ttot_nxt = T_REL;
            state_nxt = S_DISP;
          end else if (MEM_RDATA_I[7:5] == 3'b001 && MEM_RDATA_I[2:0] == 3'h0) begin
            cls_nxt = CL_REL_C;
            take_nxt = cond_met({1'b0, MEM_RDATA_I[4:3]}, FLAGS_I);
            ttot_nxt = take_nxt ? T_REL : T_REL_NOT;
            state_nxt = S_DISP;
          end else if (MEM_RDATA_I == OP_LOOP) begin
            cls_nxt = CL_LOOP;
            cnt_nxt = dec;
            cnt_we_nxt = 1'b1;
            take_nxt = dec != 8'h00;
            ttot_nxt = take_nxt ? T_LOOP_TAKEN : T_LOOP_DONE;
            state_nxt = S_DISP;
          end else if (MEM_RDATA_I == OP_CALL) begin
            cls_nxt = CL_CALL;
            ttot_nxt = T_CALL;
            state_nxt = S_OPLO;
          end else if (MEM_RDATA_I[7:6] == 2'b11 && MEM_RDATA_I[2:0] == 3'h4) begin
            cls_nxt = CL_CALL_C;
            take_nxt = cond_met(MEM_RDATA_I[5:3], FLAGS_I);
            ttot_nxt = take_nxt ? T_CALL : T_CALL_NOT;
            state_nxt = S_OPLO;
          end else if (MEM_RDATA_I == OP_EXIT) begin
            cls_nxt = CL_EXIT;
            ttot_nxt = T_EXIT;
            state_nxt = S_POPL;
          end else if (MEM_RDATA_I[7:6] == 2'b11 && MEM_RDATA_I[2:0] == 3'h0) begin
            cls_nxt = CL_EXIT_C;
            take_nxt = cond_met(MEM_RDATA_I[5:3], FLAGS_I);
            ttot_nxt = take_nxt ? T_EXIT_C : T_EXIT_NOT;
            state_nxt = take_nxt ? S_POPL : S_PAD;
          end else if (MEM_RDATA_I == OP_PFX_ED || MEM_RDATA_I == OP_PFX_DD ||
                       MEM_RDATA_I == OP_PFX_FD) begin
            cls_nxt = CL_PFX;
            pfx_nxt = MEM_RDATA_I;
            ttot_nxt = T_OTHER_PFX;
            state_nxt = S_FETCH2;
          end else begin
            cls_nxt = CL_OTHER;  // Left to other units
            take_nxt = 1'b0;
            ttot_nxt = T_OTHER;
            unh_nxt = 1'b1;
          end
        end
        // Second opcode byte after a prefix
        S_FETCH2: begin
          pc_nxt = pc_r + 16'h0001;
          state_nxt = S_PAD;
          take_nxt = 1'b0;
          if (pfx_r == OP_PFX_ED && MEM_RDATA_I == OP2_MODE1) begin
            cls_nxt = CL_MODE1;
            im_nxt = 2'h1;
            ttot_nxt = T_MODE;
          end else if (pfx_r == OP_PFX_ED && MEM_RDATA_I == OP2_MODE2) begin
            cls_nxt = CL_MODE2;
            im_nxt = 2'h2;
            ttot_nxt = T_MODE;
          end else if (pfx_r == OP_PFX_ED && MEM_RDATA_I == OP2_IRQ_EXIT) begin
            cls_nxt = CL_IRQ_EXIT;  // Same pop sequence as plain exit
            take_nxt = 1'b1;
            irqx_nxt = 1'b1;
            ttot_nxt = T_IRQ_EXIT;
            state_nxt = S_POPL;
          end else if (pfx_r != OP_PFX_ED && MEM_RDATA_I == OP2_INDIR) begin
            cls_nxt = CL_INDIR;
            take_nxt = 1'b1;
            tgt_nxt = (pfx_r == OP_PFX_DD) ? FIRST_INDEX_I : SECOND_INDEX_I;
            ttot_nxt = T_INDIR;
          end else begin
            cls_nxt = CL_OTHER;
            unh_nxt = 1'b1;
          end
        end
        // Target low byte first, then high
        S_OPLO: begin
          pc_nxt = pc_r + 16'h0001;
          tgt_nxt = {tgt_r[15:8], MEM_RDATA_I};
          state_nxt = S_OPHI;
        end
        S_OPHI: begin
          pc_nxt = pc_r + 16'h0001;
          tgt_nxt = {MEM_RDATA_I, tgt_r[7:0]};
          state_nxt = ((cls_r == CL_CALL || cls_r == CL_CALL_C) && take_r) ? S_PUSHH : S_PAD;
        end
        // Displacement taken from the address after itself
        S_DISP: begin
          pc_nxt = pc_r + 16'h0001;
          tgt_nxt = pc_nxt + {{8{MEM_RDATA_I[7]}}, MEM_RDATA_I};
          state_nxt = S_PAD;
        end
        // Push high byte below the top, then low
        S_PUSHH: begin
          sp_nxt = sp_r - 16'h0001;
          state_nxt = S_PUSHL;
        end
        S_PUSHL: begin
          sp_nxt = sp_r - 16'h0001;
          state_nxt = S_PAD;
        end
        // Pop low byte then high
        S_POPL: begin
          sp_nxt = sp_r + 16'h0001;
          tgt_nxt = {tgt_r[15:8], MEM_RDATA_I};
          state_nxt = S_POPH;
        end
        S_POPH: begin
          sp_nxt = sp_r + 16'h0001;
          tgt_nxt = {MEM_RDATA_I, tgt_r[7:0]};
          state_nxt = S_PAD;
        end
        // Idle T states up to the instruction's length
        S_PAD: begin
          if (tcnt_r == ttot_r - 5'h01) begin
            if (take_r && cls_r != CL_MODE1 && cls_r != CL_MODE2) begin
              pc_nxt = tgt_r;
            end
            done_nxt = 1'b1;
            state_nxt = S_FETCH;
          end
        end
        default: state_nxt = S_FETCH;
      endcase
      // Bus setup for the step just entered
      rd_nxt = 1'b0;
      wr_nxt = 1'b0;
      m1_nxt = 1'b0;
      unique case (state_nxt)
        S_FETCH, S_FETCH2: begin
          addr_nxt = pc_nxt;
          rd_nxt = 1'b1;
          m1_nxt = 1'b1;
        end
        S_OPLO, S_OPHI, S_DISP: begin
          addr_nxt = pc_nxt;
          rd_nxt = 1'b1;
        end
        S_PUSHH: begin
          addr_nxt = sp_nxt - 16'h0001;
          wdata_nxt = pc_nxt[15:8];
          wr_nxt = 1'b1;
        end
        S_PUSHL: begin
          addr_nxt = sp_nxt - 16'h0001;
          wdata_nxt = pc_nxt[7:0];
          wr_nxt = 1'b1;
        end
        S_POPL, S_POPH: begin
          addr_nxt = sp_nxt;
          rd_nxt = 1'b1;
        end
        default: addr_nxt = addr_r;
      endcase
    end
    // Software load of the stack pointer, in any cycle, overriding the sequencer
    if (STACK_LOAD_I) begin
      sp_nxt = STACK_VALUE_I;
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r <= S_FETCH;
      cls_r <= CL_OTHER;
      pfx_r <= 8'h00;
      take_r <= 1'b0;
      tcnt_r <= 5'h00;
      ttot_r <= T_OTHER;
      tgt_r <= PCNT_RESET;
      pc_r <= PCNT_RESET;
      sp_r <= STACK_RESET;
      im_r <= 2'h0;
      addr_r <= PCNT_RESET;
      wdata_r <= 8'h00;
      rd_r <= 1'b1;
      wr_r <= 1'b0;
      m1_r <= 1'b1;
      cnt_r <= 8'h00;
      cnt_we_r <= 1'b0;
      irqx_r <= 1'b0;
      unh_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cls_r <= cls_nxt;
      pfx_r <= pfx_nxt;
      take_r <= take_nxt;
      tcnt_r <= tcnt_nxt;
      ttot_r <= ttot_nxt;
      tgt_r <= tgt_nxt;
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      im_r <= im_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      m1_r <= m1_nxt;
      cnt_r <= cnt_nxt;
      cnt_we_r <= cnt_we_nxt;
      irqx_r <= irqx_nxt;
      unh_r <= unh_nxt;
      done_r <= done_nxt;
    end
  end

  // Outputs
  assign TSTATE_O = tick;
  assign MEM_ADDR_O = addr_r;
  assign MEM_WDATA_O = wdata_r;
  assign MEM_RD_O = rd_r;
  assign MEM_WR_O = wr_r;
  assign OPFETCH_O = m1_r;
  assign LOOP_COUNT_O = cnt_r;
  assign LOOP_COUNT_WE_O = cnt_we_r;
  assign PROGRAM_COUNTER_O = pc_r;
  assign STACK_POINTER_O = sp_r;
  assign INTERRUPT_MODE_O = im_r;
  assign IRQ_EXIT_O = irqx_r;
  assign UNHANDLED_O = unh_r;
  assign INSN_DONE_O = done_r;

  // ==========================================================
  // Assertions
  // ==========================================================
  a_mode_one: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    last && cls_r == CL_MODE1 |-> tcnt_r == 5'h07 && im_r == 2'h1)
    else $error("mode one length or value wrong");
  a_mode_two: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    last && cls_r == CL_MODE2 |=> INTERRUPT_MODE_O == 2'h2 && $stable(pc_r))
    else $error("mode two not set");
  a_abs_target: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    last && cls_r == CL_ABS |=> tcnt_r == 5'h0A && pc_r == $past(tgt_r))
    else $error("absolute branch wrong");
  a_indir_copy: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    last && cls_r == CL_INDIR |-> tcnt_r == 5'h07 ##1 (pc_r == $past(tgt_r)))
    else $error("indirect branch wrong");
  a_abs_cond_len: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    last && cls_r == CL_ABS_C && !take_r |=> pc_r == $past(pc_r) && tcnt_r == 5'h0A)
    else $error("untaken conditional branch moved");
  a_rel_len: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    last && (cls_r == CL_REL || cls_r == CL_REL_C) |-> tcnt_r == (take_r ? 5'h0B : 5'h06))
    else $error("relative branch length wrong");
  a_loop_fall: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    last && cls_r == CL_LOOP && cnt_r == 8'h00 |-> tcnt_r == 5'h07 && !take_r)
    else $error("loop fall through wrong");
  a_call_push: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    tick && state_r == S_PUSHL |-> MEM_WR_O && MEM_ADDR_O == sp_r - 16'h0001 ##1
    sp_r == $past(sp_r) - 16'h0001)
    else $error("call push wrong");
  a_exit_pop: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    tick && state_r == S_POPH |=> sp_r == $past(sp_r) + 16'h0001 &&
    tgt_r[15:8] == $past(MEM_RDATA_I))
    else $error("exit pop wrong");
  a_exit_cond_len: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    last && cls_r == CL_EXIT_C |-> tcnt_r == (take_r ? 5'h0A : 5'h04))
    else $error("conditional exit length wrong");
endmodule : pcbu_core

// file: inc/pcbu_pkg.sv
// Constants, encodings and timing for the program control branch unit
package pcbu_pkg;
  // ==========================================================
  // Opcodes
  // ==========================================================
  localparam logic [7:0] OP_ABS = 8'hC3;
  localparam logic [7:0] OP_CALL = 8'hCD;
  localparam logic [7:0] OP_EXIT = 8'hC9;
  localparam logic [7:0] OP_REL = 8'h18;
  localparam logic [7:0] OP_LOOP = 8'h10;
  localparam logic [7:0] OP_PFX_ED = 8'hED;
  localparam logic [7:0] OP_PFX_DD = 8'hDD;
  localparam logic [7:0] OP_PFX_FD = 8'hFD;
  localparam logic [7:0] OP2_MODE1 = 8'h56;
  localparam logic [7:0] OP2_MODE2 = 8'h5E;
  localparam logic [7:0] OP2_IRQ_EXIT = 8'h4D;
  localparam logic [7:0] OP2_INDIR = 8'hE9;
  // ==========================================================
  // Flag bit positions
  // ==========================================================
  localparam int FLAG_S = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_PV = 2;
  localparam int FLAG_C = 0;
  // ==========================================================
  // Instruction lengths in T states
  // ==========================================================
  localparam logic [4:0] T_MODE = 5'h08;
  localparam logic [4:0] T_ABS = 5'h0A;
  localparam logic [4:0] T_INDIR = 5'h08;
  localparam logic [4:0] T_REL = 5'h0C;
  localparam logic [4:0] T_REL_NOT = 5'h07;
  localparam logic [4:0] T_LOOP_TAKEN = 5'h0D;
  localparam logic [4:0] T_LOOP_DONE = 5'h08;
  localparam logic [4:0] T_CALL = 5'h11;
  localparam logic [4:0] T_CALL_NOT = 5'h0A;
  localparam logic [4:0] T_EXIT = 5'h0A;
  localparam logic [4:0] T_EXIT_C = 5'h0B;
  localparam logic [4:0] T_EXIT_NOT = 5'h05;
  localparam logic [4:0] T_IRQ_EXIT = 5'h0E;
  localparam logic [4:0] T_OTHER = 5'h04;
  localparam logic [4:0] T_OTHER_PFX = 5'h08;
  // ==========================================================
  // Reset values and clocking
  // ==========================================================
  localparam logic [15:0] PCNT_RESET = 16'h0000;
  localparam logic [15:0] STACK_RESET = 16'hFFFF;
  localparam int TSTATE_DIV_DEF = 4;  // Core cycles per T state
  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [3:0] {
    S_FETCH = 4'h0, S_FETCH2 = 4'h1, S_OPLO = 4'h2, S_OPHI = 4'h3, S_DISP = 4'h4,
    S_PUSHH = 4'h5, S_PUSHL = 4'h6, S_POPL = 4'h7, S_POPH = 4'h8, S_PAD = 4'h9
  } pcbu_state_t;
  typedef enum logic [3:0] {
    CL_OTHER = 4'h0, CL_MODE1 = 4'h1, CL_MODE2 = 4'h2, CL_ABS = 4'h3, CL_INDIR = 4'h4,
    CL_ABS_C = 4'h5, CL_REL = 4'h6, CL_REL_C = 4'h7, CL_LOOP = 4'h8, CL_CALL = 4'h9,
    CL_CALL_C = 4'hA, CL_EXIT = 4'hB, CL_EXIT_C = 4'hC, CL_IRQ_EXIT = 4'hD,
    CL_PFX = 4'hE
  } pcbu_cls_t;
endpackage : pcbu_pkg

// file: logic/pcbu_tstate_div.sv
// T state enable divider for the program control branch unit
module pcbu_tstate_div
  import pcbu_pkg::*;
#(
  parameter int DIV = TSTATE_DIV_DEF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic tick_o
);
  // ==========================================================
  // Parameter check
  // ==========================================================
  if (DIV < 2 || DIV > 256) begin : g_bad_div
    $error("pcbu_tstate_div: DIV must be 2 to 256");
  end

  logic [7:0] cnt_r;  // Core cycles within T state
  logic [7:0] cnt_nxt;

  // Next count, wraps at DIV
  always_comb begin
    cnt_nxt = (cnt_r == 8'(DIV - 1)) ? 8'h00 : cnt_r + 8'h01;
  end

  // Count register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // One-cycle pulse per T state
  assign tick_o = (cnt_r == 8'(DIV - 1));
endmodule : pcbu_tstate_div

// file: bench/pcbu_mem_model.sv
// Byte-wide memory model that answers the branch unit's bus
module pcbu_mem_model (
  input wire logic clk_i,
  input wire logic tick_i,
  input wire logic [15:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic opfetch_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output int exit_seen_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Storage and read path
  // ==========================================================
  logic [7:0] mem [0:65535]; // Whole address space
  logic [7:0] last_r = 8'h00; // Last byte handed out
  logic prev_pfx_r = 1'b0; // Last opcode fetch was the ED prefix
  int seen_r = 0; // Interrupt exit sequences seen
  // Data only while read is high, else stale value inverted
  assign rdata_o = rd_i ? mem[addr_i] : ~last_r;
  assign exit_seen_o = seen_r;
  // Commit writes at the T state edge, watch opcode fetches
  always @(posedge clk_i) begin
    if (tick_i && rd_i) begin
      last_r <= mem[addr_i];
    end
    if (tick_i && wr_i) begin
      mem[addr_i] <= wdata_i;
    end
    if (tick_i && rd_i && opfetch_i) begin
      if (prev_pfx_r && mem[addr_i] == 8'h4D) begin
        seen_r <= seen_r + 1;
      end
      prev_pfx_r <= (mem[addr_i] == 8'hED);
    end
  end
endmodule : pcbu_mem_model

// file: bench/tb_top.sv
// Self-checking bench for the program control branch unit
`define CHK(nm, got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb_top;
  import pcbu_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  // ==========================================================
  logic clk = 1'b0; // 50 MHz core clock
  logic rst_n = 1'b0; // Active low reset
  logic [7:0] loop_cnt = 8'h02; // Loop counter register model
  logic [7:0] flags = 8'h00; // Flag register model
  logic [7:0] rdata, wdata, loop_o;
  logic [15:0] addr, pc, sp;
  logic [1:0] mode;
  logic tick, rd, wr, opf, loop_we, irq_x, unh, done;
  logic [23:0] got; // Measured length and counter
  int error_cnt = 0;
  int tests_run = 0;
  int irq_cnt = 0;
  int unh_cnt = 0;
  int seen;
  always #10 clk = ~clk;
  // ==========================================================
  // Design and memory
  // ==========================================================
  pcbu_core #(.TSTATE_DIV(2)) dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .MEM_RDATA_I(rdata),
    .FLAGS_I(flags), .FIRST_INDEX_I(16'h0200), .SECOND_INDEX_I(16'h0300),
    .LOOP_COUNT_I(loop_cnt), .STACK_LOAD_I(1'b0), .STACK_VALUE_I(16'h0000), .TSTATE_O(tick),
    .MEM_ADDR_O(addr), .MEM_WDATA_O(wdata), .MEM_RD_O(rd), .MEM_WR_O(wr), .OPFETCH_O(opf),
    .LOOP_COUNT_O(loop_o), .LOOP_COUNT_WE_O(loop_we), .PROGRAM_COUNTER_O(pc),
    .STACK_POINTER_O(sp), .INTERRUPT_MODE_O(mode), .IRQ_EXIT_O(irq_x), .UNHANDLED_O(unh),
    .INSN_DONE_O(done));
  pcbu_mem_model u_mem (.clk_i(clk), .tick_i(tick), .addr_i(addr), .rd_i(rd), .wr_i(wr),
    .opfetch_i(opf), .wdata_i(wdata), .rdata_o(rdata), .exit_seen_o(seen));
  // Counter write-back and pulse counting
  always @(posedge clk) begin
    if (loop_we === 1'b1) loop_cnt <= loop_o;
    if (irq_x === 1'b1) irq_cnt <= irq_cnt + 1;
    if (unh === 1'b1) unh_cnt <= unh_cnt + 1;
  end
  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic put(input logic [15:0] a, input logic [23:0] b, input int n);
    for (int i = 0; i < n; i++) u_mem.mem[a + 16'(i)] = b[23 - 8 * i -: 8];
  endtask : put
  // Count T states up to the done pulse, then capture the counter
  task automatic step();
    int len;
    int n;
    len = 0;
    for (n = 0; n < 400; n++) begin
      @(negedge clk);
      if (tick === 1'b1) len++;
      if (done === 1'b1) break;
    end
    if (n == 400) begin
      error_cnt++;
      $display("ERROR step timeout");
    end
    got = {8'(len), pc};
  endtask : step
  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_modes();
    step(); `CHK("mode1", {got, 6'(mode)}, {8'h08, 16'h0002, 6'h01})
    step(); `CHK("mode2", {got, 6'(mode)}, {8'h08, 16'h0004, 6'h02})
  endtask : t_modes
  task automatic t_jumps();
    step(); `CHK("abs", got, {8'h0A, 16'h0100})
    step(); `CHK("indir1", got, {8'h08, 16'h0200})
    step(); `CHK("indir2", got, {8'h08, 16'h0300})
    step(); `CHK("abs z", got, {8'h0A, 16'h0303})
    step(); `CHK("abs nz", got, {8'h0A, 16'h0400})
  endtask : t_jumps
  task automatic t_rel();
    step(); `CHK("rel fwd", got, {8'h0C, 16'h0422})
    step(); `CHK("rel back", got, {8'h0C, 16'h0414})
    step(); `CHK("rel c", got, {8'h07, 16'h0416})
    step(); `CHK("rel nc", got, {8'h0C, 16'h0480})
  endtask : t_rel
  task automatic t_loop();
    step(); `CHK("loop taken", {got, loop_o}, {8'h0D, 16'h0480, 8'h01})
    step(); `CHK("loop done", {got, loop_o}, {8'h08, 16'h0482, 8'h00})
  endtask : t_loop
  task automatic t_calls();
    step(); `CHK("call", {got, sp}, {8'h11, 16'h0600, 16'hFFFD})
    `CHK("push", {u_mem.mem[16'hFFFE], u_mem.mem[16'hFFFD]}, 16'h0485)
    step(); `CHK("call z", {got, sp}, {8'h0A, 16'h0603, 16'hFFFD})
    step(); `CHK("call nz", {got, sp}, {8'h11, 16'h0700, 16'hFFFB})
  endtask : t_calls
  task automatic t_exits();
    step(); `CHK("exit z", {got, sp}, {8'h05, 16'h0701, 16'hFFFB})
    step(); `CHK("exit nz", {got, sp}, {8'h0B, 16'h0606, 16'hFFFD})
    step(); `CHK("irq exit", {got, sp}, {8'h0E, 16'h0485, 16'hFFFF})
    `CHK("irq pulse", irq_cnt, 1)
    `CHK("exit watch", seen, 1)
    step(); `CHK("call2", got, {8'h11, 16'h0800})
    step(); `CHK("exit", {got, sp}, {8'h0A, 16'h0488, 16'hFFFF})
  endtask : t_exits
  task automatic t_conds();
    step(); `CHK("exit pe", got, {8'h05, 16'h0489})
    step(); `CHK("exit m", got, {8'h05, 16'h048A})
    step(); `CHK("abs po", got, {8'h0A, 16'h0900})
    step(); `CHK("abs p", got, {8'h0A, 16'h0A00})
    step(); `CHK("other", {got, 8'(unh_cnt)}, {8'h04, 16'h0A01, 8'h01})
  endtask : t_conds
  // Conditions tested with set flags: S, Z, P/V and C all high
  task automatic t_flags();
    @(posedge clk);
    flags <= 8'hC5;
    step(); `CHK("abs z set", got, {8'h0A, 16'h0B00})
    step(); `CHK("rel c set", got, {8'h0C, 16'h0B04})
    step(); `CHK("call z set", {got, sp}, {8'h11, 16'h0C00, 16'hFFFD})
    step(); `CHK("exit pe set", {got, sp}, {8'h0B, 16'h0B07, 16'hFFFF})
    step(); `CHK("abs m set", got, {8'h0A, 16'h0D00})
    step(); `CHK("rel nz set", got, {8'h07, 16'h0D02})
  endtask : t_flags
  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial begin
    put(16'h0000, 24'hED56ED, 3);
    put(16'h0003, 24'h5EC300, 3);
    put(16'h0006, 24'h010000, 1);
    put(16'h0100, 24'hDDE900, 2);
    put(16'h0200, 24'hFDE900, 2);
    put(16'h0300, 24'hCA1003, 3);
    put(16'h0303, 24'hC20004, 3);
    put(16'h0400, 24'h182000, 2);
    put(16'h0422, 24'h18F000, 2);
    put(16'h0414, 24'h380530, 3);
    put(16'h0417, 24'h680000, 1);
    put(16'h0480, 24'h10FECD, 3);
    put(16'h0483, 24'h0006CD, 3);
    put(16'h0486, 24'h0008E8, 3);
    put(16'h0489, 24'hF8E200, 3);
    put(16'h048C, 24'h090000, 1);
    put(16'h0600, 24'hCC0007, 3);
    put(16'h0603, 24'hC40007, 3);
    put(16'h0606, 24'hED4D00, 2);
    put(16'h0700, 24'hC8C000, 2);
    put(16'h0800, 24'hC90000, 1);
    put(16'h0900, 24'hF2000A, 3);
    put(16'h0A00, 24'h000000, 1);
    put(16'h0A01, 24'hCA000B, 3);
    put(16'h0B00, 24'h380200, 2);
    put(16'h0B04, 24'hCC000C, 3);
    put(16'h0B07, 24'hFA000D, 3);
    put(16'h0C00, 24'hE80000, 1);
    put(16'h0D00, 24'h200500, 2);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_modes();
    t_jumps();
    t_rel();
    t_loop();
    t_calls();
    t_exits();
    t_conds();
    t_flags();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk);
    $display("ERROR watchdog expired");
    error_cnt++;
    end_sim();
  end
endmodule : tb_top
